// >>> logic/vlan_address_lookup.v
// VLAN-mode forwarding decision and address learning for a five-port switch
`timescale 1ns/1ps
`default_nettype none
`include "vlan_lookup_defs.vh"

module vlan_address_lookup #(
  parameter NPORTS = 5,
  parameter NVLAN = 16,
  parameter CPU_PORT = 4
) (
  input wire sys_clk,
  input wire rst,
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r,
  input wire frm_req,
  input wire [2:0] frm_src_port,
  input wire frm_tagged,
  input wire [11:0] frm_vid,
  input wire [47:0] frm_da,
  input wire [47:0] frm_sa,
  input wire [3:0] frm_special_mask,
  output reg busy_r,
  output reg tbl_req_r,
  output reg [47:0] tbl_da_r,
  output reg [47:0] tbl_sa_r,
  output reg [3:0] tbl_filter_id_r,
  input wire tbl_ack,
  input wire static_hit,
  input wire [63:0] static_entry,
  input wire dyn_da_hit,
  input wire [63:0] dyn_da_entry,
  input wire dyn_sa_hit,
  output reg learn_r,
  output reg refresh_r,
  output reg [2:0] learn_port_r,
  output reg fwd_valid_r,
  output reg fwd_drop_r,
  output reg [NPORTS-1:0] fwd_ports_r
);

  localparam ST_IDLE = 2'd0;
  localparam ST_VLAN = 2'd1;
  localparam ST_TBL = 2'd2;
  localparam integer TBL_WAIT_I = `TBL_WAIT_CYC;
  localparam [7:0] TBL_WAIT = TBL_WAIT_I[7:0];

  // Register storage
  reg [`VT_W-1:0] vlan_tab_r [0:NVLAN-1];
  reg [1:0] port_ctrl_r [0:NPORTS-1];
  reg [11:0] port_default_vlan_r [0:NPORTS-1];
  reg vlan_mode_r;
  reg [15:0] drops_r;
  reg [15:0] lookups_r;

  // Frame context held for the look-up
  reg [1:0] state_r;
  reg [2:0] src_r;
  reg tagged_r;
  reg [11:0] vid_r;
  reg [NPORTS-1:0] member_r;
  reg [7:0] wait_r;

  wire [NVLAN-1:0] vhit;
  reg vfound;
  reg [3:0] vidx;
  reg [11:0] eff_vid;
  reg [1:0] pctl;
  reg [NPORTS-1:0] member_nxt;
  reg [3:0] fid_nxt;
  reg drop_nxt;
  reg sfid_ok;
  reg [NPORTS-1:0] dyn_onehot;
  reg [NPORTS-1:0] dest_nxt;
  reg [NPORTS-1:0] spec_ports;
  wire spec_take;
  wire tbl_expired;
  wire [15:0] drops_inc;
  wire [15:0] lookups_inc;
  wire sel_vlan;
  wire sel_pctrl;
  wire sel_port_default_vlan;
  wire sel_gctrl;
  wire sel_status;
  wire sel_drops;
  wire sel_lookups;
  integer i_pick;
  integer i_dyn;
  integer i_spec;
  integer i_rst;

  // Register group selects on the register port
  assign sel_vlan = reg_addr < (`REG_VLAN_BASE + NVLAN);
  assign sel_pctrl = (reg_addr >= `REG_PCTRL_BASE) && (reg_addr < (`REG_PCTRL_BASE + NPORTS));
  assign sel_port_default_vlan = (reg_addr >= `REG_PORT_DEFAULT_VLAN_BASE) && (reg_addr < (`REG_PORT_DEFAULT_VLAN_BASE + NPORTS));
  assign sel_gctrl = reg_addr == `REG_GCTRL;
  assign sel_status = reg_addr == `REG_STATUS;
  assign sel_drops = reg_addr == `REG_DROPS;
  assign sel_lookups = reg_addr == `REG_LOOKUPS;

  // Special-tag bypass: processor port with a non-zero mask
  assign spec_take = (frm_src_port == CPU_PORT) && (frm_special_mask != 4'h0);

  // Mask widened to the port vector; the processor port never sends to itself
  always @* begin
    spec_ports = {NPORTS{1'b0}};
    for (i_spec = 0; i_spec < 4; i_spec = i_spec + 1) begin
      spec_ports[i_spec] = frm_special_mask[i_spec];
    end
  end

  // Counter increments and the table answer deadline
  assign drops_inc = drops_r + 16'h0001;
  assign lookups_inc = lookups_r + 16'h0001;
  assign tbl_expired = wait_r == 8'h00;

  // Comparators, one per table entry
  genvar g;
  generate
    for (g = 0; g < NVLAN; g = g + 1) begin : g_match
      vlan_entry_match u_match (
        .entry(vlan_tab_r[g]),
        .vid(vid_r),
        .hit(vhit[g])
      );
    end
  endgenerate

  // Pick the first matching entry
  always @* begin
    vfound = 1'b0;
    vidx = 4'h0;
    for (i_pick = NVLAN - 1; i_pick >= 0; i_pick = i_pick - 1) begin
      if (vhit[i_pick]) begin
        vfound = 1'b1;
        vidx = i_pick[3:0];
      end
    end
  end

  // Admission checks and filter id for the held frame
  always @* begin
    pctl = port_ctrl_r[src_r];
    member_nxt = {NPORTS{1'b1}};
    fid_nxt = 4'h0;
    drop_nxt = 1'b0;
    if (vlan_mode_r) begin
      member_nxt = vlan_tab_r[vidx][`VT_MEMBER];
      fid_nxt = vlan_tab_r[vidx][`VT_FID];
      if (!vfound) begin
        drop_nxt = 1'b1;
      end
      if (pctl[`PC_INGRESS_FILT - 5] && !member_nxt[src_r]) begin
        drop_nxt = 1'b1;
      end
      if (pctl[`PC_DISCARD_NDEF - 5] && tagged_r && (vid_r != port_default_vlan_r[src_r])) begin
        drop_nxt = 1'b1;
      end
    end
  end

  // Destination choice once both address tables answered
  always @* begin
    sfid_ok = !static_entry[`ST_USE_FILTER_ID_FLAG] || (static_entry[`ST_FID] == tbl_filter_id_r);
    dyn_onehot = {NPORTS{1'b0}};
    for (i_dyn = 0; i_dyn < NPORTS; i_dyn = i_dyn + 1) begin
      if (dyn_da_entry[`DY_PORT] == i_dyn[2:0]) begin
        dyn_onehot[i_dyn] = 1'b1;
      end
    end
    if (static_hit && sfid_ok) begin
      dest_nxt = static_entry[`ST_PORTS];
    end else if (dyn_da_hit) begin
      dest_nxt = dyn_onehot;
    end else begin
      dest_nxt = member_r;
    end
  end

  // Identifier used for the VLAN table search
  always @* begin
    if (!frm_tagged || frm_vid == `VID_NULL) begin
      eff_vid = port_default_vlan_r[frm_src_port];
    end else begin
      eff_vid = frm_vid;
    end
  end

  // Register writes and reads
  always @(posedge sys_clk) begin
    if (rst) begin
      for (i_rst = 0; i_rst < NVLAN; i_rst = i_rst + 1) begin
        vlan_tab_r[i_rst] <= {`VT_W{1'b0}};
      end
      for (i_rst = 0; i_rst < NPORTS; i_rst = i_rst + 1) begin
        port_ctrl_r[i_rst] <= 2'b00;
        port_default_vlan_r[i_rst] <= `PORT_DEFAULT_VLAN_RST;
      end
      vlan_mode_r <= `GCTRL_RST;
      reg_rdata_r <= 32'h0000_0000;
    end else begin
      reg_rdata_r <= 32'h0000_0000;
      if (reg_wr) begin
        if (sel_vlan) begin
          vlan_tab_r[reg_addr[3:0]] <= reg_wdata[`VT_W-1:0];
        end else if (sel_pctrl) begin
          port_ctrl_r[reg_addr[2:0]] <= reg_wdata[`PC_INGRESS_FILT:`PC_DISCARD_NDEF];
        end else if (sel_port_default_vlan) begin
          port_default_vlan_r[reg_addr[2:0]] <= reg_wdata[11:0];
        end else if (sel_gctrl) begin
          vlan_mode_r <= reg_wdata[`GC_VLAN_MODE];
        end
      end
      if (reg_rd) begin
        if (sel_vlan) begin
          reg_rdata_r <= {{(32-`VT_W){1'b0}}, vlan_tab_r[reg_addr[3:0]]};
        end else if (sel_pctrl) begin
          reg_rdata_r <= {25'h0, port_ctrl_r[reg_addr[2:0]], 5'h00};
        end else if (sel_port_default_vlan) begin
          reg_rdata_r <= {20'h00000, port_default_vlan_r[reg_addr[2:0]]};
        end else if (sel_gctrl) begin
          reg_rdata_r <= {31'h0, vlan_mode_r};
        end else if (sel_status) begin
          reg_rdata_r <= {28'h0000000, tbl_filter_id_r[3:1], busy_r};
        end else if (sel_drops) begin
          reg_rdata_r <= {16'h0000, drops_r};
        end else if (sel_lookups) begin
          reg_rdata_r <= {16'h0000, lookups_r};
        end
      end
    end
  end

  // Look-up sequencer
  always @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      src_r <= 3'd0;
      tagged_r <= 1'b0;
      vid_r <= 12'h000;
      member_r <= {NPORTS{1'b0}};
      wait_r <= 8'h00;
      tbl_req_r <= 1'b0;
      tbl_da_r <= 48'h0000_0000_0000;
      tbl_sa_r <= 48'h0000_0000_0000;
      tbl_filter_id_r <= 4'h0;
      learn_r <= 1'b0;
      refresh_r <= 1'b0;
      learn_port_r <= 3'd0;
      fwd_valid_r <= 1'b0;
      fwd_drop_r <= 1'b0;
      fwd_ports_r <= {NPORTS{1'b0}};
      drops_r <= 16'h0000;
      lookups_r <= 16'h0000;
    end else begin
      fwd_valid_r <= 1'b0;
      learn_r <= 1'b0;
      refresh_r <= 1'b0;
      tbl_req_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (frm_req) begin
            lookups_r <= lookups_inc;
            if (spec_take) begin
              // Processor chooses ports itself, VLAN checks ignored
              fwd_valid_r <= 1'b1;
              fwd_drop_r <= 1'b0;
              fwd_ports_r <= spec_ports;
            end else begin
              state_r <= ST_VLAN;
              busy_r <= 1'b1;
              src_r <= frm_src_port;
              tagged_r <= frm_tagged && (frm_vid != `VID_NULL);
              vid_r <= eff_vid;
              tbl_da_r <= frm_da;
              tbl_sa_r <= frm_sa;
            end
          end
        end
        ST_VLAN: begin
          if (drop_nxt) begin
            // Dropped frames never reach the address tables, so nothing is learned
            fwd_valid_r <= 1'b1;
            fwd_drop_r <= 1'b1;
            fwd_ports_r <= {NPORTS{1'b0}};
            drops_r <= drops_inc;
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            tbl_filter_id_r <= fid_nxt;
            member_r <= member_nxt;
            learn_port_r <= src_r;
            tbl_req_r <= 1'b1;
            wait_r <= TBL_WAIT;
            state_r <= ST_TBL;
          end
        end
        ST_TBL: begin
          if (tbl_ack) begin
            fwd_valid_r <= 1'b1;
            fwd_drop_r <= 1'b0;
            fwd_ports_r <= dest_nxt;
            learn_r <= !dyn_sa_hit;
            refresh_r <= dyn_sa_hit;
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
          end else if (tbl_expired) begin
            // Tables never answered: drop rather than hang the port
            fwd_valid_r <= 1'b1;
            fwd_drop_r <= 1'b1;
            fwd_ports_r <= {NPORTS{1'b0}};
            drops_r <= drops_inc;
            busy_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            wait_r <= wait_r - 8'h01;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> logic/vlan_lookup_defs.vh
// Offsets, field positions, reset values and timing counts for the VLAN look-up block
`ifndef VLAN_LOOKUP_DEFS_VH
`define VLAN_LOOKUP_DEFS_VH

// Register indices on the register port
`define REG_VLAN_BASE 6'h00
`define REG_PCTRL_BASE 6'h10
`define REG_PORT_DEFAULT_VLAN_BASE 6'h18
`define REG_GCTRL 6'h20
`define REG_STATUS 6'h21
`define REG_DROPS 6'h22
`define REG_LOOKUPS 6'h23

// VLAN table entry layout
`define VT_VID 11:0
`define VT_FID 15:12
`define VT_MEMBER 20:16
`define VT_VALID 21
`define VT_W 22

// Per-port control bits
`define PC_INGRESS_FILT 6
`define PC_DISCARD_NDEF 5

// Global control bits
`define GC_VLAN_MODE 0

// Static and dynamic address table entry fields
`define ST_PORTS 52:48
`define ST_USE_FILTER_ID_FLAG 55
`define ST_FID 59:56
`define DY_PORT 54:52

// Reset values and the null identifier
`define GCTRL_RST 1'b1
`define PORT_DEFAULT_VLAN_RST 12'h001
`define VID_NULL 12'h000

// Address table answer time limit
`define TBL_WAIT_NS 6400
`define CLK_NS 100
`define TBL_WAIT_CYC (`TBL_WAIT_NS / `CLK_NS)

`endif

// >>> logic/vlan_entry_match.v
// One VLAN table entry comparator
`timescale 1ns/1ps
`default_nettype none
`include "vlan_lookup_defs.vh"

module vlan_entry_match (
  input wire [`VT_W-1:0] entry,
  input wire [11:0] vid,
  output wire hit
);

  // Only a valid entry with the same identifier matches
  assign hit = entry[`VT_VALID] && (entry[`VT_VID] == vid);

endmodule
`default_nettype wire

// >>> verif/vlan_lookup_asserts.sv
// Port checker for the VLAN look-up block
`timescale 1ns/1ps
`default_nettype none
module vlan_lookup_asserts #(parameter NPORTS = 5) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic frm_req,
  input wire logic busy_r,
  input wire logic [2:0] frm_src_port,
  input wire logic [3:0] frm_special_mask,
  input wire logic tbl_req_r,
  input wire logic tbl_ack,
  input wire logic static_hit,
  input wire logic [63:0] static_entry,
  input wire logic dyn_da_hit,
  input wire logic [63:0] dyn_da_entry,
  input wire logic dyn_sa_hit,
  input wire logic learn_r,
  input wire logic refresh_r,
  input wire logic fwd_valid_r,
  input wire logic fwd_drop_r,
  input wire logic [NPORTS-1:0] fwd_ports_r
);
  logic wait_r;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Open table query, so stray answers are not mistaken for real ones
  always @(posedge sys_clk) begin
    if (rst || tbl_ack || fwd_valid_r) wait_r <= 1'b0;
    else if (tbl_req_r) wait_r <= 1'b1;
  end
  sequence s_take; frm_req && !busy_r; endsequence
  sequence s_ans; wait_r && tbl_ack; endsequence
  property p_busy; s_take ##0 !(frm_src_port == 3'h4 && frm_special_mask != 4'h0) |=> busy_r;
  endproperty
  property p_spec; s_take ##0 (frm_src_port == 3'h4 && frm_special_mask != 4'h0) |=>
    fwd_valid_r && !fwd_drop_r && fwd_ports_r == {1'b0, $past(frm_special_mask)}; endproperty
  property p_tmo; tbl_req_r |-> ##[1:66] fwd_valid_r; endproperty
  property p_stat; s_ans ##0 (static_hit && !static_entry[55]) |=>
    !fwd_drop_r && fwd_ports_r == $past(static_entry[52:48]); endproperty
  property p_dyn; s_ans ##0 (!static_hit && dyn_da_hit) |=>
    fwd_ports_r == (5'h01 << $past(dyn_da_entry[54:52])); endproperty
  property p_lrn; s_ans ##0 !dyn_sa_hit |=> learn_r && !refresh_r; endproperty
  property p_ref; s_ans ##0 dyn_sa_hit |=> refresh_r && !learn_r; endproperty
  property p_pair; (learn_r || refresh_r) |-> fwd_valid_r && !fwd_drop_r; endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  a_spec: assert property (p_spec) else $error("mask bypass wrong");
  a_tmo: assert property (p_tmo) else $error("no decision");
  a_stat: assert property (p_stat) else $error("static ports wrong");
  a_dyn: assert property (p_dyn) else $error("dynamic port wrong");
  a_lrn: assert property (p_lrn) else $error("no learn");
  a_ref: assert property (p_ref) else $error("no refresh");
  a_pair: assert property (p_pair) else $error("learn on drop");
endmodule
bind vlan_address_lookup vlan_lookup_asserts #(.NPORTS(NPORTS)) u_chk (.*);
`default_nettype wire

// >>> verif/addr_table_model.sv
// Address table model answering look-up queries
`timescale 1ns/1ps
`default_nettype none
module addr_table_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tbl_req_r,
  input wire logic mute,
  input wire logic [3:0] dly,
  input wire logic [2:0] hits,
  input wire logic [63:0] st_cfg,
  input wire logic [63:0] dy_cfg,
  output logic tbl_ack,
  output logic static_hit,
  output logic [63:0] static_entry,
  output logic dyn_da_hit,
  output logic [63:0] dyn_da_entry,
  output logic dyn_sa_hit
);
  logic [3:0] cnt_r;
  // Query to answer delay; mute never answers
  always @(posedge sys_clk) begin
    if (rst) cnt_r <= 4'h0;
    else if (tbl_req_r && !mute) cnt_r <= dly;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  // Answer valid only in the ack cycle, inverted otherwise
  assign tbl_ack = cnt_r == 4'h1;
  assign {static_hit, dyn_da_hit, dyn_sa_hit} = tbl_ack ? hits : ~hits;
  assign static_entry = tbl_ack ? st_cfg : ~st_cfg;
  assign dyn_da_entry = tbl_ack ? dy_cfg : ~dy_cfg;
endmodule
`default_nettype wire

// >>> verif/vlan_address_lookup_tb_top.sv
// Testbench for the VLAN look-up block
`timescale 1ns/1ps
`default_nettype none
module vlan_address_lookup_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, frm_req = 1'b0;
  logic frm_tagged = 1'b0, mute = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0, got;
  logic [2:0] frm_src_port = 3'h0, hits = 3'h0;
  logic [11:0] frm_vid = 12'h000;
  logic [47:0] frm_da = 48'h0a0b0c0d0e0f, frm_sa = 48'h020304050607;
  logic [3:0] frm_special_mask = 4'h0, dly = 4'h1;
  logic [63:0] st_cfg = 64'h0, dy_cfg = 64'h0;
  wire logic [31:0] reg_rdata_r;
  wire logic busy_r, tbl_req_r, tbl_ack, static_hit, dyn_da_hit, dyn_sa_hit;
  wire logic learn_r, refresh_r, fwd_valid_r, fwd_drop_r;
  wire logic [47:0] tbl_da_r, tbl_sa_r;
  wire logic [3:0] tbl_filter_id_r;
  wire logic [63:0] static_entry, dyn_da_entry;
  wire logic [2:0] learn_port_r;
  wire logic [4:0] fwd_ports_r;
  int num_errors = 0, n_checks = 0, cyc = 0;
  vlan_address_lookup u_vlan_address_lookup (.*);
  addr_table_model u_addr_table_model (.*);
  initial forever #50 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    n_checks++;
    if (a !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, a);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk("rdata", e, reg_rdata_r);
  endtask
  // One request; got packs drop, learn, refresh and ports
  task automatic look(input logic [2:0] p, input logic t, input logic [11:0] v,
    input logic [3:0] m);
    int k;
    @(posedge sys_clk);
    frm_src_port <= p;
    frm_tagged <= t;
    frm_vid <= v;
    frm_special_mask <= m;
    frm_req <= 1'b1;
    @(posedge sys_clk);
    frm_req <= 1'b0;
    @(negedge sys_clk);
    for (k = 0; k < 90 && fwd_valid_r !== 1'b1; k++) @(negedge sys_clk);
    got = {24'h0, fwd_drop_r, learn_r, refresh_r, fwd_ports_r};
    chk("decision", 32'h1, {31'h0, fwd_valid_r});
  endtask
  task automatic s_regs();
    rd(6'h20, 32'h1);
    rd(6'h18, 32'h1);
    wr(6'h00, 32'h00335064);
    wr(6'h01, 32'h003f2001);
    wr(6'h3f, 32'hffff);
    wr(6'h12, 32'h40);
    wr(6'h13, 32'h20);
    rd(6'h00, 32'h00335064);
    rd(6'h3f, 32'h0);
    rd(6'h12, 32'h40);
  endtask
  task automatic s_flood();
    hits = 3'b000;
    look(3'h1, 1'b1, 12'h000, 4'h0);
    chk("flood", 32'h5f, got);
    chk("fid", 32'h2, tbl_filter_id_r);
    chk("da", 32'h0c0d0e0f, tbl_da_r[31:0]);
    chk("sa", 32'h04050607, tbl_sa_r[31:0]);
    chk("learn port", 32'h1, learn_port_r);
  endtask
  task automatic s_dyn();
    hits = 3'b011;
    dly = 4'h3;
    dy_cfg = 64'h0030000000000000;
    look(3'h0, 1'b1, 12'h064, 4'h0);
    chk("dyn", 32'h28, got);
    chk("fid", 32'h5, tbl_filter_id_r);
    dly = 4'h1;
  endtask
  task automatic s_static();
    hits = 3'b101;
    st_cfg = 64'h0586000000000000;
    look(3'h0, 1'b1, 12'h064, 4'h0);
    chk("static", 32'h26, got);
    st_cfg = 64'h0986000000000000;
    look(3'h0, 1'b1, 12'h064, 4'h0);
    chk("mismatch", 32'h33, got);
    st_cfg = 64'h0906000000000000;
    look(3'h0, 1'b1, 12'h064, 4'h0);
    chk("no fid use", 32'h26, got);
    hits = 3'b111;
    st_cfg = 64'h0986000000000000;
    dy_cfg = 64'h0010000000000000;
    look(3'h0, 1'b1, 12'h064, 4'h0);
    chk("mismatch dyn", 32'h22, got);
  endtask
  task automatic s_drop();
    hits = 3'b000;
    look(3'h0, 1'b1, 12'h0aa, 4'h0);
    chk("bad vid", 32'h4, got[7:5]);
    look(3'h2, 1'b1, 12'h064, 4'h0);
    chk("ingress", 32'h4, got[7:5]);
    look(3'h3, 1'b1, 12'h064, 4'h0);
    chk("non default", 32'h4, got[7:5]);
    look(3'h3, 1'b0, 12'h064, 4'h0);
    chk("default", 32'h5f, got);
  endtask
  task automatic s_spec();
    look(3'h4, 1'b1, 12'h0aa, 4'h5);
    chk("special", 32'h05, got);
    mute = 1'b1;
    look(3'h1, 1'b0, 12'h000, 4'h0);
    chk("no answer", 32'h4, got[7:5]);
    mute = 1'b0;
    rd(6'h21, 32'h2);
    rd(6'h22, 32'h4);
    rd(6'h23, 32'hc);
  endtask
  // VLAN mode off: no VLAN drop, filter id 0, all ports
  task automatic s_mode();
    wr(6'h20, 32'h0);
    look(3'h0, 1'b1, 12'h0aa, 4'h0);
    chk("mode off", 32'h5f, got);
    chk("fid off", 32'h0, tbl_filter_id_r);
    wr(6'h20, 32'h1);
    rd(6'h20, 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    s_regs();
    s_flood();
    s_dyn();
    s_static();
    s_drop();
    s_spec();
    s_mode();
    tally_and_finish();
  end
endmodule
`default_nettype wire
